/* File: hw/dog_pkg.sv */
package dog_pkg;

    // ----------------------------------------------------------------
    // register map, word indices inside the control frame
    // ----------------------------------------------------------------
    // frame base as seen by software, kept for address documentation
    localparam logic [15:0] FRAME_BASE       = 16'h7020;
    // index of each register inside the frame; byte address = 4 * index
    localparam logic [5:0]  IDX_COUNTER      = 6'h03;
    localparam logic [5:0]  IDX_SERVICE_KEY  = 6'h05;
    localparam logic [5:0]  IDX_CONTROL      = 6'h09;
    localparam logic [5:0]  IDX_SYS_CTRL_TWO = 6'h0a;
    localparam logic [5:0]  IDX_IRQ_STATUS   = 6'h0b;
    localparam logic [5:0]  IDX_IRQ_MASK     = 6'h0c;
    localparam int          ADDR_W           = 8;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int          CTL_FLAG_BIT     = 7;     // reset-caused-by-dog flag
    localparam int          CTL_DIS_BIT      = 6;
    localparam int          CTL_CHK_LSB      = 3;
    localparam logic [2:0]  CTL_CHK_PATTERN  = 3'h5;  // check bits 101
    localparam logic [2:0]  CTL_PS_RESET     = 3'h0;  // fastest rate
    localparam int          SCS2_DIS_BIT     = 5;     // disable permit bit

    // ----------------------------------------------------------------
    // service key values and interrupt status bits
    // ----------------------------------------------------------------
    localparam logic [7:0]  KEY_ARM          = 8'h55;
    localparam logic [7:0]  KEY_CLEAR        = 8'haa;
    localparam int          IRQ_BAD_KEY      = 0;
    localparam int          IRQ_BAD_CHECK    = 1;
    localparam int          IRQ_OVERFLOW     = 2;
    localparam int          IRQ_SERVICED     = 3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          BASE_DIV         = 512;
    localparam int          CLK_HZ           = 20000000;
    localparam int          RST_PULSE_NS     = 400;
    localparam int          RST_PULSE_CYC    = (RST_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;

    // ----------------------------------------------------------------
    // axi responses
    // ----------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

/* File: hw/dog_prescaler.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// base divider and selectable prescaler, one tick per rate period
// ----------------------------------------------------------------
module dog_prescaler #(
    parameter int BASE_DIV = 512
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       clear,
    input  wire logic [2:0] sel,
    // output
    output logic            tick
);
    typedef struct packed {
        logic [15:0] base_cnt;
        logic [5:0]  pre_cnt;
    } state_t;

    state_t state_q;
    state_t state_d;
    logic   base_tick;
    logic   [5:0] pre_max;

    // elaboration check: the base counter is only 16 bits wide
    if (BASE_DIV < 2 || BASE_DIV > 65536)
    begin : g_bad_div
        $error("dog_prescaler: BASE_DIV out of range");
    end

    // prescale table: 00x by 1, then doubling to 64
    always_comb
    begin
        unique case (sel)
            3'h0, 3'h1: pre_max = 6'h00;
            3'h2:       pre_max = 6'h01;
            3'h3:       pre_max = 6'h03;
            3'h4:       pre_max = 6'h07;
            3'h5:       pre_max = 6'h0f;
            3'h6:       pre_max = 6'h1f;
            3'h7:       pre_max = 6'h3f;
        endcase
    end

    assign base_tick = (state_q.base_cnt == 16'(BASE_DIV - 1));
    assign tick      = base_tick && (state_q.pre_cnt >= pre_max);

    // a service clears both stages so a full period follows it
    always_comb
    begin
        state_d = state_q;
        if (clear)
        begin
            state_d.base_cnt = 16'h0000;
            state_d.pre_cnt  = 6'h00;
        end
        else if (base_tick)
        begin
            state_d.base_cnt = 16'h0000;
            state_d.pre_cnt  = tick ? 6'h00 : state_q.pre_cnt + 6'h01;
        end
        else
            state_d.base_cnt = state_q.base_cnt + 16'h0001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= '0;
        else
            state_q <= state_d;
    end
endmodule // dog_prescaler

/* File: hw/watchdog_timer.sv */
`timescale 1ns/1ns
module watchdog_timer #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // system side
    output logic             dog_reset_req,
    output logic             irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic             aw_held;
        logic [7:0]       aw_addr;
        logic             w_held;
        logic [7:0]       w_data;
        logic             w_lane0;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [7:0]       rdata;
        logic [CNT_W-1:0] count;
        logic             armed;
        logic [2:0]       ps_sel;
        logic             dis_req;
        logic             flag;
        logic [7:0]       scs2;
        logic [3:0]       irq_stat;
        logic [3:0]       irq_mask;
        logic [7:0]       rst_cnt;
    } state_t;

    state_t state_q;
    state_t state_d;

    logic        tick;
    logic        svc_clear;
    logic        disabled;
    logic        wr_go;
    logic        rd_go;
    logic [5:0]  wr_idx;
    logic [5:0]  rd_idx;
    logic [3:0]  ev;
    logic        bad_key;
    logic        bad_chk;
    logic        overflow;
    logic        fault;
    logic        pre_clear;

    // elaboration checks on the parameter and on package values that the
    // read-back layout and the pulse counter hard-wire
    if (CNT_W < 2 || CNT_W > 16)
    begin : g_bad_cnt_w
        $error("watchdog_timer: CNT_W out of range");
    end
    if (dog_pkg::RST_PULSE_CYC < 1 || dog_pkg::RST_PULSE_CYC > 255)
    begin : g_bad_pulse
        $error("watchdog_timer: reset pulse length out of range");
    end
    if (dog_pkg::KEY_ARM == dog_pkg::KEY_CLEAR)
    begin : g_bad_keys
        $error("watchdog_timer: service key values must differ");
    end
    if (dog_pkg::CTL_CHK_LSB != 3 || dog_pkg::CTL_DIS_BIT != 6 || dog_pkg::CTL_FLAG_BIT != 7)
    begin : g_bad_fields
        $error("watchdog_timer: control read-back layout is fixed");
    end
    if (dog_pkg::ADDR_W != 8)
    begin : g_bad_addr_w
        $error("watchdog_timer: bus address ports are 8 bits");
    end

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // a service or a fault restarts the prescaler, so a full period follows
    assign pre_clear = svc_clear || fault;

    dog_prescaler #(
        .BASE_DIV (dog_pkg::BASE_DIV)
    ) u_pre (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (pre_clear),
        .sel     (state_q.ps_sel),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // a write goes when both halves are held and no response is pending
    assign wr_go  = state_q.aw_held && state_q.w_held && !state_q.bvalid;
    assign rd_go  = s_axi_arvalid && !state_q.rvalid;
    assign wr_idx = state_q.aw_addr[7:2];
    assign rd_idx = s_axi_araddr[7:2];

    assign s_axi_awready = !state_q.aw_held;
    assign s_axi_wready  = !state_q.w_held;
    assign s_axi_arready = !state_q.rvalid;
    assign s_axi_bvalid  = state_q.bvalid;
    assign s_axi_bresp   = state_q.bresp;
    assign s_axi_rvalid  = state_q.rvalid;
    assign s_axi_rresp   = state_q.rresp;
    assign s_axi_rdata   = {24'h000000, state_q.rdata};

    // disable honoured only with the permit bit set
    assign disabled  = state_q.dis_req && state_q.scs2[dog_pkg::SCS2_DIS_BIT];

    // ----------------------------------------------------------------
    // key and check evaluation
    // ----------------------------------------------------------------
    // arm key then clear key services; anything else is a fault
    always_comb
    begin
        bad_key   = 1'b0;
        svc_clear = 1'b0;
        bad_chk   = 1'b0;
        if (wr_go && wr_idx == dog_pkg::IDX_SERVICE_KEY && s_axi_wstrb_q0())
        begin
            if (state_q.w_data == dog_pkg::KEY_CLEAR && state_q.armed)
                svc_clear = 1'b1;
            else if (state_q.w_data != dog_pkg::KEY_ARM)
                bad_key = 1'b1;
        end
        if (wr_go && wr_idx == dog_pkg::IDX_CONTROL && s_axi_wstrb_q0())
            bad_chk = state_q.w_data[dog_pkg::CTL_CHK_LSB +: 3] != dog_pkg::CTL_CHK_PATTERN;
    end

    // low byte lane enable captured with the data
    function automatic logic s_axi_wstrb_q0();
        return state_q.w_lane0;
    endfunction

    // overflow on the tick that would wrap the counter
    assign overflow = tick && !disabled && (&state_q.count);
    assign fault    = bad_key || bad_chk || overflow;

    // status bits placed by their package index rather than by position
    always_comb
    begin
        ev                         = 4'h0;
        ev[dog_pkg::IRQ_BAD_KEY]   = bad_key;
        ev[dog_pkg::IRQ_BAD_CHECK] = bad_chk;
        ev[dog_pkg::IRQ_OVERFLOW]  = overflow;
        ev[dog_pkg::IRQ_SERVICED]  = svc_clear;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        // channel capture, either order
        if (s_axi_awvalid && !state_q.aw_held)
        begin
            state_d.aw_held = 1'b1;
            state_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_q.w_held)
        begin
            // upper lanes only: nothing stored, still answered with okay
            state_d.w_held  = 1'b1;
            state_d.w_lane0 = s_axi_wstrb[0];
            state_d.w_data  = s_axi_wdata[7:0];
        end
        if (state_q.bvalid && s_axi_bready)
            state_d.bvalid = 1'b0;
        if (state_q.rvalid && s_axi_rready)
            state_d.rvalid = 1'b0;

        // free-running count from release of reset
        if (tick && !disabled)
            state_d.count = state_q.count + 1'b1;

        // register writes
        if (wr_go)
        begin
            state_d.aw_held = 1'b0;
            state_d.w_held  = 1'b0;
            state_d.bvalid  = 1'b1;
            state_d.bresp   = dog_pkg::RESP_OKAY;
            // a write with lane 0 off changes nothing but is still answered
            if (state_q.w_lane0)
            begin
                unique case (wr_idx)
                    dog_pkg::IDX_SERVICE_KEY:
                        state_d.armed = (state_q.w_data == dog_pkg::KEY_ARM);
                    dog_pkg::IDX_CONTROL:
                        if (!bad_chk)
                        begin
                            state_d.dis_req = state_q.w_data[dog_pkg::CTL_DIS_BIT];
                            state_d.ps_sel  = state_q.w_data[2:0];
                            if (state_q.w_data[dog_pkg::CTL_FLAG_BIT])
                                state_d.flag = 1'b0;
                        end
                    dog_pkg::IDX_SYS_CTRL_TWO:
                        state_d.scs2 = state_q.w_data;
                    dog_pkg::IDX_IRQ_STATUS:
                        state_d.irq_stat = state_q.irq_stat & ~state_q.w_data[3:0];
                    dog_pkg::IDX_IRQ_MASK:
                        state_d.irq_mask = state_q.w_data[3:0];
                    dog_pkg::IDX_COUNTER:
                        state_d.bresp = dog_pkg::RESP_OKAY;
                    default:
                        state_d.bresp = dog_pkg::RESP_SLVERR;
                endcase
            end
        end
        if (svc_clear)
            state_d.count = '0;

        // reads of the frame
        if (rd_go)
        begin
            state_d.rvalid = 1'b1;
            state_d.rresp  = dog_pkg::RESP_OKAY;
            unique case (rd_idx)
                dog_pkg::IDX_COUNTER:      state_d.rdata = 8'(state_q.count);
                dog_pkg::IDX_SERVICE_KEY:  state_d.rdata = 8'h00;
                dog_pkg::IDX_CONTROL:
                    state_d.rdata = {state_q.flag, state_q.dis_req, dog_pkg::CTL_CHK_PATTERN, state_q.ps_sel};
                dog_pkg::IDX_SYS_CTRL_TWO: state_d.rdata = state_q.scs2;
                dog_pkg::IDX_IRQ_STATUS:   state_d.rdata = {4'h0, state_q.irq_stat};
                dog_pkg::IDX_IRQ_MASK:     state_d.rdata = {4'h0, state_q.irq_mask};
                default:
                begin
                    state_d.rdata = 8'h00;
                    state_d.rresp = dog_pkg::RESP_SLVERR;
                end
            endcase
        end

        // sticky events; set wins over the same-cycle clear
        state_d.irq_stat = state_d.irq_stat | ev;

        // fault: stretch a reset pulse, restart counter at fastest rate
        if (fault)
        begin
            state_d.rst_cnt = 8'(dog_pkg::RST_PULSE_CYC);
            state_d.flag    = 1'b1;
            state_d.count   = '0;
            state_d.armed   = 1'b0;
            state_d.ps_sel  = dog_pkg::CTL_PS_RESET;
            state_d.dis_req = 1'b0;
        end
        else if (state_q.rst_cnt != 8'h00)
            state_d.rst_cnt = state_q.rst_cnt - 8'h01;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // reset state is already a running dog at the fastest rate
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    // ----------------------------------------------------------------
    // system outputs
    // ----------------------------------------------------------------
    // the request stays high for the whole stretched pulse
    assign dog_reset_req = (state_q.rst_cnt != 8'h00);
    assign irq           = |(state_q.irq_stat & state_q.irq_mask);
endmodule // watchdog_timer

/* File: verification/dog_chk.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// port checker for the watchdog block
// ----------------------------------------------------------------
module dog_chk (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // system side
    input wire logic        dog_reset_req
);
    localparam logic [7:0] KEY_A = {dog_pkg::IDX_SERVICE_KEY, 2'b00};
    localparam logic [7:0] CTL_A = {dog_pkg::IDX_CONTROL, 2'b00};
    logic                  wr_go;

    // both halves taken at one edge; lane 0 off means the write is dropped
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_pulse_len: assert property (
        $rose(dog_reset_req) |-> dog_reset_req [*8] ##1 !dog_reset_req) else $error("reset pulse length wrong");
    a_bad_key: assert property (
        wr_go && s_axi_awaddr == KEY_A && s_axi_wdata[7:0] != dog_pkg::KEY_ARM
        && s_axi_wdata[7:0] != dog_pkg::KEY_CLEAR |-> ##[1:3] dog_reset_req) else $error("bad key kept quiet");
    a_bad_check: assert property (
        wr_go && s_axi_awaddr == CTL_A && s_axi_wdata[5:3] != dog_pkg::CTL_CHK_PATTERN
        |-> ##[1:3] dog_reset_req) else $error("bad check bits kept quiet");
    a_wr_answer: assert property (
        wr_go |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
    a_b_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_r_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bytes not zero");
endmodule // dog_chk

bind watchdog_timer dog_chk dog_chk_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .dog_reset_req);

/* File: verification/watchdog_timer_tb.sv */
`timescale 1ns/1ns
module watchdog_timer_tb;
    // short counter keeps the fastest expiry at 2048 cycles
    localparam int         CW    = 2;
    localparam int         T0    = dog_pkg::BASE_DIV << CW;
    localparam logic [1:0] OK    = dog_pkg::RESP_OKAY;
    localparam logic [7:0] A_CNT = {dog_pkg::IDX_COUNTER, 2'b00};
    localparam logic [7:0] A_KEY = {dog_pkg::IDX_SERVICE_KEY, 2'b00};
    localparam logic [7:0] A_CTL = {dog_pkg::IDX_CONTROL, 2'b00};
    localparam logic [7:0] A_SC2 = {dog_pkg::IDX_SYS_CTRL_TWO, 2'b00};
    localparam logic [7:0] A_ST  = {dog_pkg::IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] A_MSK = {dog_pkg::IDX_IRQ_MASK, 2'b00};
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dog_reset_req, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          err_total = 0;
    int          compares  = 0;
    int          cyc       = 0;
    int          n;

    watchdog_timer #(.CNT_W(CW)) watchdog_timer_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .dog_reset_req, .irq);

    // clock, and a ceiling so a stuck handshake cannot hang the run
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            end_sim;
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_awvalid || s_axi_wvalid);
        // late ready so the response has to stand
        while (s_axi_bvalid !== 1'b1)
            @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er, "bresp");
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do
            @(posedge aclk);
        while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1)
            @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        check(s_axi_rresp, er, "rresp");
    endtask
    task automatic svc;
        wr(A_KEY, 32'(dog_pkg::KEY_ARM), OK);
        wr(A_KEY, 32'(dog_pkg::KEY_CLEAR), OK);
    endtask
    // waits for the reset pulse; t = 0 means it must follow within 64 cycles
    task automatic tmo(input int t);
        int k;
        k = 0;
        while (dog_reset_req !== 1'b1 && k < t + t / 8 + 64)
        begin
            @(posedge aclk);
            k++;
        end
        check(k >= t - t / 4 - t / 8 && k < t + t / 8 + 64, 1'b1, "expiry time");
        repeat (9) @(posedge aclk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_boot;
        tmo(T0);
        rd(A_CTL, OK, d);
        check(d[7], 1'b1, "reset flag");
        check(d[2:0], dog_pkg::CTL_PS_RESET, "rate after reset");
        check(d[31:8], 24'h0, "upper bytes");
        rd(8'h00, dog_pkg::RESP_SLVERR, d);
        wr(8'h04, 32'h0, dog_pkg::RESP_SLVERR);
    endtask
    task automatic t_key;
        repeat (1100) @(posedge aclk);
        rd(A_CNT, OK, d);
        check(d[7:0] != 8'h0, 1'b1, "counter running");
        svc;
        rd(A_CNT, OK, d);
        check(d[7:0], 8'h0, "counter cleared");
        check(dog_reset_req, 1'b0, "good key quiet");
        wr(A_KEY, 32'h12, OK);
        tmo(0);
        // clearing value without the arming value first is a fault too
        wr(A_KEY, 32'(dog_pkg::KEY_CLEAR), OK);
        tmo(0);
    endtask
    task automatic t_ctl;
        // disabled lane 0 must drop even a bad pattern
        s_axi_wstrb <= 4'h0;
        wr(A_CTL, 32'h30, OK);
        s_axi_wstrb <= 4'hf;
        check(dog_reset_req, 1'b0, "lane off");
        for (int k = 0; k < 8; k++)
        begin
            wr(A_CTL, 32'(k) << 3, OK);
            if (k != 5)
                tmo(0);
            else
                check(dog_reset_req, 1'b0, "good pattern");
        end
        wr(A_CTL, 32'ha8, OK);
        rd(A_CTL, OK, d);
        check(d[7], 1'b0, "flag cleared");
    endtask
    task automatic t_rates;
        for (int k = 1; k < 5; k++)
        begin
            wr(A_CTL, 32'h28 | 32'(k), OK);
            svc;
            tmo(T0 << (k < 2 ? 0 : k - 1));
        end
    endtask
    task automatic t_dis;
        wr(A_CTL, 32'h68, OK);
        svc;
        tmo(T0);
        wr(A_SC2, 32'h2000, OK);
        rd(A_SC2, OK, d);
        check(d[31:8], 24'h0, "upper byte");
        check(d[7:0], 8'h0, "upper write ignored");
        wr(A_CTL, 32'h68, OK);
        svc;
        tmo(T0);
        wr(A_SC2, 32'h20, OK);
        wr(A_CTL, 32'h68, OK);
        svc;
        n = 0;
        repeat (3 * T0 / 2) @(posedge aclk) n = n + 32'(dog_reset_req);
        check(n, 0, "disabled");
        wr(A_SC2, 32'h0, OK);
        wr(A_CTL, 32'h28, OK);
    endtask
    task automatic t_irq;
        // every event has happened by now and none has been cleared yet
        rd(A_ST, OK, d);
        check(d[3:0], 4'hf, "all events latched");
        wr(A_ST, 32'hf, OK);
        rd(A_ST, OK, d);
        check(d[3:0], 4'h0, "status cleared");
        wr(A_KEY, 32'h12, OK);
        tmo(0);
        rd(A_ST, OK, d);
        check(d[dog_pkg::IRQ_BAD_KEY], 1'b1, "bad key status");
        check(irq, 1'b0, "masked");
        wr(A_MSK, 32'h1, OK);
        check(irq, 1'b1, "unmasked");
        wr(A_ST, 32'h1, OK);
        check(irq, 1'b0, "acknowledged");
    endtask

    // reset, then every scenario in turn
    initial
    begin
        aresetn       = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        s_axi_awaddr  = 8'h0;
        s_axi_araddr  = 8'h0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_boot;
        t_key;
        t_ctl;
        t_rates;
        t_dis;
        t_irq;
        end_sim;
    end
endmodule // watchdog_timer_tb
